// *** pbds_pkg.sv ***
package pbds_pkg;
    // Bus phases, one-hot
    typedef enum logic [8:0] {
        PH_FREE     = 9'h001,
        PH_ARB      = 9'h002,
        PH_SELECT   = 9'h004,
        PH_RESELECT = 9'h008,
        PH_COMMAND  = 9'h010,
        PH_DATA_IN  = 9'h020,
        PH_DATA_OUT = 9'h040,
        PH_STATUS   = 9'h080,
        PH_MSG_IN   = 9'h100
    } pbds_phase_e;
    localparam int          PBDS_ID_W      = 3;
    localparam int          PBDS_DATA_W    = 8;
    localparam logic [7:0]  PBDS_DATA_RST  = 8'h00;
    localparam logic        PBDS_PAR_ODD   = 1'b1;
    // Control line field positions in the control vector
    localparam int          PBDS_CTL_CD    = 0;
    localparam int          PBDS_CTL_IO    = 1;
    localparam int          PBDS_CTL_MSG   = 2;
    localparam int          PBDS_CTL_REQ   = 3;
    localparam int          PBDS_CTL_W     = 4;
    localparam logic [3:0]  PBDS_CTL_RST   = 4'h0;
endpackage

// *** pbds_bus_if.sv ***
interface pbds_bus_if;
    import pbds_pkg::*;
    // Device end drivers
    logic [7:0] devData;
    logic [7:0] devDataOe;
    logic       devPar;
    logic       devParOe;
    logic       devBusyOe;
    logic       devSelOe;
    logic       devRstOe;
    logic [3:0] devCtl;
    logic [3:0] devCtlOe;
    logic [1:0] devInitOut;
    logic [1:0] devInitOe;
    // Far end drivers
    logic [7:0] farData;
    logic [7:0] farDataOe;
    logic       farPar;
    logic       farParOe;
    logic       farBusyOe;
    logic       farSelOe;
    logic       farRstOe;
    logic [3:0] farCtl;
    logic [3:0] farCtlOe;
    logic [1:0] farInitOut;
    logic [1:0] farInitOe;
    // Resolved line levels, true = asserted, released lines read false
    logic [7:0] busData;
    logic       busPar;
    logic       busBusy;
    logic       busSel;
    logic       busRst;
    logic [3:0] busCtl;
    logic [1:0] busInit;
    assign busData = (devData & devDataOe) | (farData & farDataOe);
    assign busPar  = (devPar & devParOe) | (farPar & farParOe);
    assign busBusy = devBusyOe | farBusyOe;
    assign busSel  = devSelOe | farSelOe;
    assign busRst  = devRstOe | farRstOe;
    assign busCtl  = (devCtl & devCtlOe) | (farCtl & farCtlOe);
    assign busInit = (devInitOut & devInitOe) | (farInitOut & farInitOe);
    modport dev (
        output devData, devDataOe, devPar, devParOe, devBusyOe, devSelOe,
        output devRstOe, devCtl, devCtlOe, devInitOut, devInitOe,
        input  busData, busPar, busBusy, busSel, busRst, busCtl, busInit
    );
    modport far (
        output farData, farDataOe, farPar, farParOe, farBusyOe, farSelOe,
        output farRstOe, farCtl, farCtlOe, farInitOut, farInitOe,
        input  busData, busPar, busBusy, busSel, busRst, busCtl, busInit
    );
endinterface

// *** pbds_dev_end.sv ***
module pbds_dev_end
    import pbds_pkg::*;
#(
    parameter logic [PBDS_ID_W-1:0] OWN_ID = 3'h7
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // Bus side
    pbds_bus_if.dev                     bus,
    // User side: phase and role
    input  wire pbds_phase_e            phase,
    input  wire logic                   isTarget,
    input  wire logic                   contend,
    input  wire logic                   busyReq,
    input  wire logic                   selReq,
    input  wire logic                   rstReq,
    // User side: payload
    input  wire logic [PBDS_DATA_W-1:0] txData,
    input  wire logic [PBDS_CTL_W-1:0]  txCtl,
    input  wire logic                   txAck,
    input  wire logic                   txAtn,
    // User side: observed bus
    output logic [PBDS_DATA_W-1:0]      rxData,
    output logic                        rxParOk,
    output logic                        rxRst
);
    // Driver flops: level and enable for data, parity, control and initiator lines; enable only for busy, select and reset
    logic [PBDS_DATA_W-1:0] dataOe_ff;
    logic [PBDS_DATA_W-1:0] data_ff;
    logic                   parOe_ff;
    logic                   par_ff;
    logic                   busyOe_ff;
    logic                   selOe_ff;
    logic                   rstOe_ff;
    logic [PBDS_CTL_W-1:0]  ctl_ff;
    logic [PBDS_CTL_W-1:0]  ctlOe_ff;
    logic [1:0]             init_ff;
    logic [1:0]             initOe_ff;
    // Receive synchroniser stages
    logic [PBDS_DATA_W-1:0] rxSync1_ff;
    logic [PBDS_DATA_W-1:0] rxSync2_ff;
    logic                   parSync1_ff;
    logic                   parSync2_ff;
    logic                   rstSync1_ff;
    logic                   rstSync2_ff;
    // Phase and role decode
    logic                   sendDir;
    logic                   targPhase;
    logic                   busyMay;
    logic                   selMay;

    // Which side sends the data byte in this phase
    always_comb begin
        targPhase = (phase == PH_COMMAND) || (phase == PH_DATA_IN) || (phase == PH_DATA_OUT)
                 || (phase == PH_STATUS) || (phase == PH_MSG_IN);
        unique case (phase)
            PH_SELECT:   sendDir = !isTarget;
            PH_RESELECT: sendDir = isTarget;
            PH_COMMAND:  sendDir = !isTarget;
            PH_DATA_IN:  sendDir = isTarget;
            PH_DATA_OUT: sendDir = !isTarget;
            PH_STATUS:   sendDir = isTarget;
            PH_MSG_IN:   sendDir = isTarget;
            default:     sendDir = 1'b0;
        endcase
    end

    // Data byte and parity drivers
    always_ff @(posedge clock) begin
        if (!reset_n || rxRst) begin
            dataOe_ff <= PBDS_DATA_RST;
            data_ff   <= PBDS_DATA_RST;
            parOe_ff  <= 1'b0;
            par_ff    <= 1'b0;
        end else if (phase == PH_ARB && contend) begin
            dataOe_ff <= 8'h01 << OWN_ID;
            data_ff   <= 8'h01 << OWN_ID;
            parOe_ff  <= 1'b0;
            par_ff    <= 1'b1;
        end else if (sendDir) begin
            dataOe_ff <= 8'hFF;
            data_ff   <= txData;
            parOe_ff  <= 1'b1;
            par_ff    <= ~^txData;
        end else begin
            dataOe_ff <= PBDS_DATA_RST;
            data_ff   <= PBDS_DATA_RST;
            parOe_ff  <= 1'b0;
            par_ff    <= 1'b0;
        end
    end

    // Which phases and roles may source busy and select
    always_comb begin
        busyMay = (phase == PH_ARB && contend)
               || ((phase == PH_SELECT || phase == PH_RESELECT) && busyReq)
               || (targPhase && isTarget && busyReq);
        unique case (phase)
            PH_ARB:      selMay = contend && selReq;
            PH_SELECT:   selMay = !isTarget && selReq;
            PH_RESELECT: selMay = isTarget && selReq;
            default:     selMay = 1'b0;
        endcase
    end

    // Busy: enable only, released while the bus is in reset
    always_ff @(posedge clock) begin
        if (!reset_n || rxRst) begin
            busyOe_ff <= 1'b0;
        end else begin
            busyOe_ff <= busyMay;
        end
    end

    // Select: enable only, any contender or addressing side, each only with selReq
    always_ff @(posedge clock) begin
        if (!reset_n || rxRst) begin
            selOe_ff <= 1'b0;
        end else begin
            selOe_ff <= selMay;
        end
    end

    // Reset line: any role, any phase, never gated
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rstOe_ff <= 1'b0;
        end else begin
            rstOe_ff <= rstReq;
        end
    end

    // Target-only and initiator-only control lines
    always_ff @(posedge clock) begin
        if (!reset_n || rxRst) begin
            ctl_ff    <= PBDS_CTL_RST;
            ctlOe_ff  <= PBDS_CTL_RST;
            init_ff   <= 2'h0;
            initOe_ff <= 2'h0;
        end else begin
            ctl_ff    <= txCtl;
            ctlOe_ff  <= (targPhase && isTarget) ? 4'hF : 4'h0;
            init_ff   <= {txAtn, txAck};
            initOe_ff <= ((targPhase || phase == PH_SELECT) && !isTarget) ? 2'h3 : 2'h0;
        end
    end

    // Data and parity synchronisers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rxSync1_ff  <= PBDS_DATA_RST;
            rxSync2_ff  <= PBDS_DATA_RST;
            parSync1_ff <= 1'b0;
            parSync2_ff <= 1'b0;
        end else begin
            rxSync1_ff  <= bus.busData;
            rxSync2_ff  <= rxSync1_ff;
            parSync1_ff <= bus.busPar;
            parSync2_ff <= parSync1_ff;
        end
    end

    // Bus reset line synchroniser
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= bus.busRst;
            rstSync2_ff <= rstSync1_ff;
        end
    end

    // Registered observed outputs
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rxData  <= PBDS_DATA_RST;
            rxParOk <= 1'b0;
            rxRst   <= 1'b0;
        end else begin
            rxData  <= rxSync2_ff;
            rxParOk <= (^{rxSync2_ff, parSync2_ff}) == PBDS_PAR_ODD;
            rxRst   <= rstSync2_ff;
        end
    end

    // Bus drivers come straight from flops
    assign bus.devData    = data_ff;
    assign bus.devDataOe  = dataOe_ff;
    assign bus.devPar     = par_ff;
    assign bus.devParOe   = parOe_ff;
    assign bus.devBusyOe  = busyOe_ff;
    assign bus.devSelOe   = selOe_ff;
    assign bus.devRstOe   = rstOe_ff;
    assign bus.devCtl     = ctl_ff;
    assign bus.devCtlOe   = ctlOe_ff;
    assign bus.devInitOut = init_ff;
    assign bus.devInitOe  = initOe_ff;
endmodule

// *** pbds_far_end.sv ***
module pbds_far_end
    import pbds_pkg::*;
#(
    parameter logic [PBDS_ID_W-1:0] OWN_ID = 3'h0
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // Bus side
    pbds_bus_if.far                     bus,
    // User side: phase and role
    input  wire pbds_phase_e            phase,
    input  wire logic                   isTarget,
    input  wire logic                   contend,
    input  wire logic                   busyReq,
    input  wire logic                   selReq,
    input  wire logic                   rstReq,
    // User side: payload
    input  wire logic [PBDS_DATA_W-1:0] txData,
    input  wire logic [PBDS_CTL_W-1:0]  txCtl,
    input  wire logic                   txAck,
    input  wire logic                   txAtn,
    // User side: observed bus
    output logic [PBDS_DATA_W-1:0]      rxData,
    output logic                        rxParOk,
    output logic                        rxRst
);
    logic [PBDS_DATA_W-1:0] dataOe_ff;
    logic [PBDS_DATA_W-1:0] data_ff;
    logic                   parOe_ff;
    logic                   par_ff;
    logic                   busyOe_ff;
    logic                   selOe_ff;
    logic                   rstOe_ff;
    logic [PBDS_CTL_W-1:0]  ctl_ff;
    logic [PBDS_CTL_W-1:0]  ctlOe_ff;
    logic [1:0]             initOe_ff;
    logic [1:0]             init_ff;
    logic [PBDS_DATA_W:0]   sync1_ff;
    logic [PBDS_DATA_W:0]   sync2_ff;
    logic                   rstSync1_ff;
    logic                   rstSync2_ff;
    logic                   sendDir;
    logic                   targPhase;

    // Sending side per phase
    always_comb begin
        targPhase = (phase == PH_COMMAND) || (phase == PH_DATA_IN) || (phase == PH_DATA_OUT)
                 || (phase == PH_STATUS) || (phase == PH_MSG_IN);
        unique case (phase)
            PH_SELECT, PH_COMMAND, PH_DATA_OUT: sendDir = !isTarget;
            PH_RESELECT, PH_DATA_IN, PH_STATUS, PH_MSG_IN: sendDir = isTarget;
            default: sendDir = 1'b0;
        endcase
    end

    // Data and parity drivers
    always_ff @(posedge clock) begin
        if (!reset_n || rxRst || !(sendDir || (phase == PH_ARB && contend))) begin
            dataOe_ff <= PBDS_DATA_RST;
            data_ff   <= PBDS_DATA_RST;
            parOe_ff  <= 1'b0;
            par_ff    <= 1'b0;
        end else if (phase == PH_ARB) begin
            dataOe_ff <= 8'h01 << OWN_ID;
            data_ff   <= 8'h01 << OWN_ID;
            parOe_ff  <= 1'b0;
            par_ff    <= 1'b1;
        end else begin
            dataOe_ff <= 8'hFF;
            data_ff   <= txData;
            parOe_ff  <= 1'b1;
            par_ff    <= ~^txData;
        end
    end

    // Wired-OR, control and initiator lines
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            busyOe_ff <= 1'b0;
            selOe_ff  <= 1'b0;
            rstOe_ff  <= 1'b0;
            ctl_ff    <= PBDS_CTL_RST;
            ctlOe_ff  <= PBDS_CTL_RST;
            init_ff   <= 2'h0;
            initOe_ff <= 2'h0;
        end else begin
            busyOe_ff <= !rxRst && ((phase == PH_ARB && contend)
                      || ((phase == PH_SELECT || phase == PH_RESELECT) && busyReq)
                      || (targPhase && isTarget && busyReq));
            selOe_ff  <= !rxRst && selReq && ((phase == PH_ARB && contend)
                      || (phase == PH_SELECT && !isTarget)
                      || (phase == PH_RESELECT && isTarget));
            rstOe_ff  <= rstReq;
            ctl_ff    <= txCtl;
            ctlOe_ff  <= (!rxRst && targPhase && isTarget) ? 4'hF : 4'h0;
            init_ff   <= {txAtn, txAck};
            initOe_ff <= (!rxRst && (targPhase || phase == PH_SELECT) && !isTarget)
                         ? 2'h3 : 2'h0;
        end
    end

    // Synchronisers and observed outputs
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
            rxData      <= PBDS_DATA_RST;
            rxParOk     <= 1'b0;
            rxRst       <= 1'b0;
        end else begin
            sync1_ff    <= {bus.busPar, bus.busData};
            sync2_ff    <= sync1_ff;
            rstSync1_ff <= bus.busRst;
            rstSync2_ff <= rstSync1_ff;
            rxData      <= sync2_ff[PBDS_DATA_W-1:0];
            rxParOk     <= (^sync2_ff) == PBDS_PAR_ODD;
            rxRst       <= rstSync2_ff;
        end
    end

    assign bus.farData    = data_ff;
    assign bus.farDataOe  = dataOe_ff;
    assign bus.farPar     = par_ff;
    assign bus.farParOe   = parOe_ff;
    assign bus.farBusyOe  = busyOe_ff;
    assign bus.farSelOe   = selOe_ff;
    assign bus.farRstOe   = rstOe_ff;
    assign bus.farCtl     = ctl_ff;
    assign bus.farCtlOe   = ctlOe_ff;
    assign bus.farInitOut = init_ff;
    assign bus.farInitOe  = initOe_ff;
endmodule

// *** pbds_bus_properties.sv ***
module pbds_bus_properties (
    // Clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    // Device end drivers
    input wire logic [7:0] devData,
    input wire logic [7:0] devDataOe,
    input wire logic       devPar,
    input wire logic       devParOe,
    input wire logic       devBusyOe,
    input wire logic [3:0] devCtlOe,
    input wire logic [1:0] devInitOe,
    // Far end drivers
    input wire logic [7:0] farData,
    input wire logic [7:0] farDataOe,
    input wire logic       farPar,
    input wire logic       farParOe,
    input wire logic       farBusyOe,
    input wire logic [3:0] farCtlOe,
    input wire logic [1:0] farInitOe,
    // Resolved reset line
    input wire logic       busRst
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Data enables: released, full byte, or own identifier bit only
    AST_DEV_OE_SHAPE: assert property (devDataOe inside {8'h00, 8'hFF, 8'h80})
        else $error("dev data enable shape wrong");
    AST_FAR_OE_SHAPE: assert property (farDataOe inside {8'h00, 8'hFF, 8'h01})
        else $error("far data enable shape wrong");
    // Contending ends drive busy, own bit, never a false parity
    AST_DEV_ARB_DRIVE: assert property (devDataOe == 8'h80 |->
        devBusyOe && devData == 8'h80 && (!devParOe || devPar))
        else $error("dev arbitration drive wrong");
    AST_FAR_ARB_DRIVE: assert property (farDataOe == 8'h01 |->
        farBusyOe && farData == 8'h01 && (!farParOe || farPar))
        else $error("far arbitration drive wrong");
    // Full byte carries odd parity
    AST_DEV_PARITY: assert property (devDataOe == 8'hFF |->
        devParOe && devPar == ~^devData)
        else $error("dev parity wrong");
    AST_FAR_PARITY: assert property (farDataOe == 8'hFF |->
        farParOe && farPar == ~^farData)
        else $error("far parity wrong");
    // Target lines and initiator lines never from one end, nor both targets
    AST_ROLE_SPLIT: assert property (!(|devCtlOe && |devInitOe) && !(|farCtlOe && |farInitOe)
        && !(|devCtlOe && |farCtlOe))
        else $error("role split broken");
    // One byte source at a time
    AST_ONE_DATA_SOURCE: assert property (devDataOe == 8'hFF |-> farDataOe == 8'h00)
        else $error("two data sources");
    // Held bus reset clears data, parity, busy, control and initiator drivers
    AST_RST_CLEARS: assert property (busRst [*6] |-> !(|{devDataOe, devParOe, devBusyOe,
        devCtlOe, devInitOe, farDataOe, farParOe, farBusyOe, farCtlOe, farInitOe}))
        else $error("drivers kept during bus reset");

    // Main scenarios
    cover property (devDataOe == 8'h80 && farDataOe == 8'h01);
    cover property (devDataOe == 8'hFF && farCtlOe == 4'hF);
    cover property (farDataOe == 8'hFF && devInitOe == 2'h3);
    cover property (busRst [*6]);
endmodule

// *** parallel_bus_driver_sources_tb_top.sv ***
module parallel_bus_driver_sources_tb_top import pbds_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        pbds_phase_e ph;
        logic        tgt;
        logic        cont;
        logic        busy;
        logic        sel;
        logic        rst;
        logic [7:0]  d;
        logic [3:0]  c;
        logic        ack;
        logic        atn;
    } pbds_user_s;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    pbds_user_s  du;
    pbds_user_s  fu;
    int          n_errors = 0;
    int          n_checks = 0;
    logic [7:0]  dRx;
    logic [7:0]  fRx;
    logic        dPok;
    logic        fPok;
    logic        dRrst;
    logic        fRrst;
    pbds_phase_e phs [9] = '{PH_FREE, PH_ARB, PH_SELECT, PH_RESELECT, PH_COMMAND, PH_DATA_IN,
                             PH_DATA_OUT, PH_STATUS, PH_MSG_IN};

    // Clock and the two ends
    always #2 clock = ~clock;
    pbds_bus_if bus ();
    pbds_dev_end i_pbds_dev_end (.clock(clock), .reset_n(reset_n), .bus(bus), .phase(du.ph),
        .isTarget(du.tgt), .contend(du.cont), .busyReq(du.busy), .selReq(du.sel),
        .rstReq(du.rst), .txData(du.d), .txCtl(du.c), .txAck(du.ack), .txAtn(du.atn),
        .rxData(dRx), .rxParOk(dPok), .rxRst(dRrst));
    pbds_far_end i_pbds_far_end (.clock(clock), .reset_n(reset_n), .bus(bus), .phase(fu.ph),
        .isTarget(fu.tgt), .contend(fu.cont), .busyReq(fu.busy), .selReq(fu.sel),
        .rstReq(fu.rst), .txData(fu.d), .txCtl(fu.c), .txAck(fu.ack), .txAtn(fu.atn),
        .rxData(fRx), .rxParOk(fPok), .rxRst(fRrst));
    pbds_bus_properties i_pbds_bus_properties (.clock(clock), .reset_n(reset_n),
        .devData(bus.devData), .devDataOe(bus.devDataOe), .devPar(bus.devPar),
        .devParOe(bus.devParOe), .devBusyOe(bus.devBusyOe), .devCtlOe(bus.devCtlOe),
        .devInitOe(bus.devInitOe), .farData(bus.farData), .farDataOe(bus.farDataOe),
        .farPar(bus.farPar), .farParOe(bus.farParOe), .farBusyOe(bus.farBusyOe),
        .farCtlOe(bus.farCtlOe), .farInitOe(bus.farInitOe), .busRst(bus.busRst));

    // Expected enables {data, par, busy, sel, rst, ctl, init}
    function automatic logic [17:0] oe_of(pbds_user_s u, logic [2:0] id);
        logic [17:0] e;
        logic        info;
        logic        addr;
        e = {11'h000, u.rst, 6'h00};
        info = u.ph inside {PH_COMMAND, PH_DATA_IN, PH_DATA_OUT, PH_STATUS, PH_MSG_IN};
        addr = u.ph inside {PH_SELECT, PH_RESELECT};
        if (u.ph == PH_FREE) return e;
        if (u.ph == PH_ARB) begin
            e[8] = u.cont;
            e[7] = u.cont & u.sel;
            e[17:10] = u.cont ? 8'h01 << id : 8'h00;
            return e;
        end
        e[8] = u.busy & (u.tgt | addr);
        e[7] = u.sel & ((u.ph == PH_SELECT) ? !u.tgt : (u.ph == PH_RESELECT && u.tgt));
        e[17:9] = (u.tgt == (u.ph inside {PH_RESELECT, PH_DATA_IN, PH_STATUS, PH_MSG_IN}))
                  ? 9'h1FF : 9'h000;
        e[5:2] = (info && u.tgt) ? 4'hF : 4'h0;
        e[1:0] = ((info || u.ph == PH_SELECT) && !u.tgt) ? 2'h3 : 2'h0;
        return e;
    endfunction

    // Expected driven levels {data, par, ctl, init}
    function automatic logic [14:0] bus_of(pbds_user_s u, logic [2:0] id);
        logic [17:0] e;
        e = oe_of(u, id);
        return {(u.ph == PH_ARB) ? e[17:10] : e[17:10] & u.d, e[9] & ~^u.d, e[5:2] & u.c,
                e[1:0] & {u.atn, u.ack}};
    endfunction

    function automatic pbds_user_s mk(pbds_phase_e ph, logic tgt, logic [7:0] d);
        return '{ph, tgt, 1'b1, 1'b1, 1'b0, 1'b0, d, 4'hA, 1'b1, 1'b0};
    endfunction

    function automatic logic [17:0] dev_oe();
        return {bus.devDataOe, bus.devParOe, bus.devBusyOe, bus.devSelOe, bus.devRstOe,
                bus.devCtlOe, bus.devInitOe};
    endfunction

    function automatic logic [17:0] far_oe();
        return {bus.farDataOe, bus.farParOe, bus.farBusyOe, bus.farSelOe, bus.farRstOe,
                bus.farCtlOe, bus.farInitOe};
    endfunction

    task automatic check(string what, logic [18:0] exp, logic [18:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Drive both ends, let bus and receivers settle, compare
    task automatic apply(pbds_user_s d, pbds_user_s f);
        logic [14:0] eb;
        du = d;
        fu = f;
        eb = bus_of(d, 3'h7) | bus_of(f, 3'h0);
        repeat (5) @(negedge clock);
        check("dev enables", {1'b0, oe_of(d, 3'h7)}, {1'b0, dev_oe()});
        check("far enables", {1'b0, oe_of(f, 3'h0)}, {1'b0, far_oe()});
        check("bus lines", {4'h0, eb}, {4'h0, bus.busData, bus.busPar, bus.busCtl, bus.busInit});
        check("dev rx", {10'h0, eb[14:7], ^eb[14:6]}, {10'h0, dRx, dPok});
        check("far rx", {10'h0, eb[14:7], ^eb[14:6]}, {10'h0, fRx, fPok});
    endtask

    // Bus reset from either end clears all other drivers
    task automatic rst_check(pbds_user_s d, pbds_user_s f);
        du = d;
        fu = f;
        repeat (8) @(negedge clock);
        check("dev reset", {1'b1, 11'h000, d.rst, 6'h00}, {dRrst, dev_oe()});
        check("far reset", {1'b1, 11'h000, f.rst, 6'h00}, {fRrst, far_oe()});
        du.rst = 1'b0;
        fu.rst = 1'b0;
        repeat (8) @(negedge clock);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end

    // Main sequence: corner cases, bus resets, then random phases
    initial begin
        pbds_user_s d;
        pbds_user_s f;
        pbds_phase_e ph;
        du = mk(PH_FREE, 1'b0, 8'h00);
        fu = mk(PH_FREE, 1'b1, 8'h00);
        void'($urandom(44));
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        apply(mk(PH_ARB, 1'b0, 8'h00), mk(PH_ARB, 1'b1, 8'hFF));
        apply(mk(PH_DATA_OUT, 1'b0, 8'h00), mk(PH_DATA_OUT, 1'b1, 8'hFF));
        apply(mk(PH_DATA_IN, 1'b0, 8'hFF), mk(PH_DATA_IN, 1'b1, 8'h7E));
        d = mk(PH_DATA_OUT, 1'b0, 8'hA5);
        f = mk(PH_DATA_OUT, 1'b1, 8'h3C);
        f.rst = 1'b1;
        rst_check(d, f);
        d = mk(PH_ARB, 1'b1, 8'h00);
        f = mk(PH_ARB, 1'b0, 8'h00);
        d.rst = 1'b1;
        rst_check(d, f);
        for (int i = 0; i < 300; i++) begin
            ph = phs[$urandom_range(8)];
            d = mk(ph, i[0], 8'($urandom));
            f = mk(ph, !i[0], 8'($urandom));
            {d.cont, d.busy, d.sel, d.c, d.ack, d.atn} = 9'($urandom);
            {f.cont, f.busy, f.sel, f.c, f.ack, f.atn} = 9'($urandom);
            apply(d, f);
        end
        tally_and_finish();
    end
endmodule
